/* design/pvi_unit.sv */
// The register offsets and the address-and-strobe port were left to the implementer.
`include "pvi_defines.svh"
module pvi_unit import pvi_pkg::*; #(
   parameter logic [19:0] SUSPEND_CYC = 20'(`PVI_SUSPEND_CYC)
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Pins from outside the clock domain
   input wire logic [7:0] key_wake_port,
   input wire logic ext_irq_a,
   input wire logic ext_irq_b,
   input wire logic counter_pin,
   input wire logic usb_se0,
   input wire logic usb_k_state,
   input wire logic usb_j_idle,
   // Peripheral events, one-cycle pulses
   input wire pvi_events_s events,
   // CPU core
   input wire logic cpu_boundary,
   input wire logic software_break_op,
   input wire logic [15:0] cpu_pc,
   input wire logic [7:0] cpu_ps,
   input wire logic [7:0] mem_rdata,
   output logic cpu_irq,
   output pvi_cpu_s cpu_out
);
   localparam logic [8:0] BUS_RESET_CYC = 9'(`PVI_BUS_RESET_CYC);

   logic [1:0] rsync_r;
   logic rst_n_i;
   pvi_state_s r;
   pvi_state_s r_nxt;
   pvi_src_t ev;
   pvi_src_t qual;
   logic take;
   logic [4:0] first_idx;
   logic a_fall;
   logic b_fall;
   logic c_fall;
   logic key_and_now;
   logic key_and_prev;

   function automatic logic [4:0] pvi_first(input pvi_src_t v);
      logic [4:0] idx;
      idx = 5'h0F;
      for (int i = 14; i >= 0; i--) begin
         if (v[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic pvi_edge(input logic now, input logic prev, input logic falling);
      return falling ? (prev & ~now) : (now & ~prev);
   endfunction

   // Reset is released through two flops so every flop leaves reset on the same edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsync_r <= 2'b00;
      end else begin
         rsync_r <= {rsync_r[0], 1'b1};
      end
   end
   assign rst_n_i = rsync_r[1];

   assign qual = r.req & r.en;
   assign cpu_irq = (|qual) & ~r.mask; // [RULE_01] [RULE_05]
   assign first_idx = pvi_first(qual);
   assign reg_rdata = r.rdata;
   assign cpu_out = r.cpu;
   assign key_and_now = &(r.pin_s2[7:0] | r.key_dir);
   assign key_and_prev = &(r.pin_d[7:0] | r.key_dir);
   assign a_fall = r.edge_sel[`PVI_EDGE_A];
   assign b_fall = r.edge_sel[`PVI_EDGE_B];
   assign c_fall = r.edge_sel[`PVI_EDGE_CNT];
   // Break is taken whatever the mask says; maskable sources only when clear
   assign take = cpu_boundary & ~r.cpu.pc_load & (r.state == PVI_IDLE)
      & (r.rst_pend | r.swb_pend | cpu_irq); // [RULE_04] [RULE_05]

   always_comb begin
      ev = '0;
      ev[0] = r.pin_s2[11] & (r.se0_cnt == BUS_RESET_CYC - 9'h001); // [RULE_13]
      ev[1] = events.sof;
      // Suspend on idle time-out, resume on K or SE0 while suspended, or transaction done
      ev[2] = (r.pin_s2[13] & (r.idle_cnt == SUSPEND_CYC - 20'h0_0001))
         | (r.suspended & ((r.pin_s2[12] & ~r.pin_d[12]) | (r.pin_s2[11] & ~r.pin_d[11])))
         | events.xact_done; // [RULE_14]
      ev[3] = events.exb_done; // [RULE_19]
      ev[4] = pvi_edge(r.pin_s2[8], r.pin_d[8], a_fall); // [RULE_15]
      ev[5] = events.timer_x; // [RULE_18]
      ev[6] = events.timer_1; // [RULE_18]
      ev[7] = events.timer_2; // [RULE_18]
      ev[8] = pvi_edge(r.pin_s2[9], r.pin_d[9], b_fall); // [RULE_15]
      ev[9] = events.hub_change; // [RULE_19]
      ev[10] = events.rx_done; // [RULE_19]
      ev[11] = events.tx_done; // [RULE_19]
      ev[12] = pvi_edge(r.pin_s2[10], r.pin_d[10], c_fall); // [RULE_16]
      ev[13] = key_and_prev & ~key_and_now; // [RULE_17]
      ev[14] = events.adc_done; // [RULE_19]
   end

   always_comb begin
      pvi_src_t clr;
      clr = '1;
      r_nxt = r;
      r_nxt.rdata = 8'h00;
      r_nxt.cpu.push_stb = 1'b0;
      r_nxt.cpu.mem_rd = 1'b0;
      r_nxt.cpu.pc_load = 1'b0;
      // Pin synchronisers; only the second stage and its delayed copy in pin_d feed logic
      r_nxt.pin_s1 = {usb_j_idle, usb_k_state, usb_se0, counter_pin, ext_irq_b, ext_irq_a, key_wake_port};
      r_nxt.pin_s2 = r.pin_s1;
      r_nxt.pin_d = r.pin_s2;
      // SE0 and idle timers saturate so each stretch raises one request
      if (r.pin_s2[11]) begin
         if (r.se0_cnt != BUS_RESET_CYC) begin
            r_nxt.se0_cnt = r.se0_cnt + 9'h001;
         end
      end else begin
         r_nxt.se0_cnt = 9'h000;
      end
      if (r.pin_s2[13]) begin
         if (r.idle_cnt != SUSPEND_CYC) begin
            r_nxt.idle_cnt = r.idle_cnt + 20'h0_0001;
         end
      end else begin
         r_nxt.idle_cnt = 20'h0_0000;
      end
      if (r.pin_s2[13] & (r.idle_cnt == SUSPEND_CYC - 20'h0_0001)) begin
         r_nxt.suspended = 1'b1;
      end else if (r.suspended & (r.pin_s2[12] | r.pin_s2[11])) begin
         r_nxt.suspended = 1'b0;
      end
      // Register writes
      if (reg_wr) begin
         if (reg_addr == `PVI_REG_REQ_LO) begin
            clr[7:0] = reg_wdata; // [RULE_03]
         end else if (reg_addr == `PVI_REG_REQ_HI) begin
            clr[14:8] = reg_wdata[6:0]; // [RULE_03]
         end else if (reg_addr == `PVI_REG_EN_LO) begin
            r_nxt.en[7:0] = reg_wdata; // [RULE_02]
         end else if (reg_addr == `PVI_REG_EN_HI) begin
            r_nxt.en[14:8] = reg_wdata[6:0]; // [RULE_02]
         end else if (reg_addr == `PVI_REG_EDGE) begin
            r_nxt.edge_sel = reg_wdata[2:0];
         end else if (reg_addr == `PVI_REG_KEY_DIR) begin
            r_nxt.key_dir = reg_wdata;
         end else if (reg_addr == `PVI_REG_CTRL) begin
            r_nxt.mask = reg_wdata[`PVI_CTRL_MASK];
         end
      end
      // Register reads, data in the following cycle only
      if (reg_rd) begin
         if (reg_addr == `PVI_REG_REQ_LO) begin
            r_nxt.rdata = r.req[7:0];
         end else if (reg_addr == `PVI_REG_REQ_HI) begin
            r_nxt.rdata = {1'b0, r.req[14:8]};
         end else if (reg_addr == `PVI_REG_EN_LO) begin
            r_nxt.rdata = r.en[7:0];
         end else if (reg_addr == `PVI_REG_EN_HI) begin
            r_nxt.rdata = {1'b0, r.en[14:8]};
         end else if (reg_addr == `PVI_REG_EDGE) begin
            r_nxt.rdata = {5'h00, r.edge_sel};
         end else if (reg_addr == `PVI_REG_KEY_DIR) begin
            r_nxt.rdata = r.key_dir;
         end else if (reg_addr == `PVI_REG_CTRL) begin
            r_nxt.rdata = {6'h00, r.suspended, r.mask};
         end else if (reg_addr == `PVI_REG_ACTIVE) begin
            r_nxt.rdata = {3'h0, r.cur_prio};
         end
      end
      // Acceptance and the stacking and vector sequence
      case (r.state)
         PVI_IDLE: begin
            if (take) begin
               r_nxt.mask = 1'b1; // [RULE_08]
               r_nxt.pc_save = cpu_pc;
               r_nxt.ps_save = cpu_ps;
               if (r.rst_pend) begin
                  r_nxt.rst_pend = 1'b0;
                  r_nxt.cur_prio = 5'h00; // [RULE_12]
                  r_nxt.cpu.mem_rd = 1'b1;
                  r_nxt.cpu.mem_addr = `PVI_VEC_TOP; // [RULE_10]
                  r_nxt.state = PVI_FETCH_LO;
               end else begin
                  if (cpu_irq) begin
                     r_nxt.cur_prio = first_idx + 5'h01; // [RULE_06] [RULE_11]
                     clr[first_idx[3:0]] = 1'b0; // [RULE_08]
                  end else begin
                     r_nxt.cur_prio = `PVI_PRIO_SWB; // [RULE_04]
                     r_nxt.swb_pend = 1'b0;
                  end
                  r_nxt.cpu.push_stb = 1'b1;
                  r_nxt.cpu.push_data = cpu_pc[15:8]; // [RULE_07]
                  r_nxt.state = PVI_PUSH_PCH;
               end
            end
         end
         PVI_PUSH_PCH: begin
            r_nxt.cpu.push_stb = 1'b1;
            r_nxt.cpu.push_data = r.pc_save[7:0]; // [RULE_07]
            r_nxt.state = PVI_PUSH_PCL;
         end
         PVI_PUSH_PCL: begin
            r_nxt.cpu.push_stb = 1'b1;
            r_nxt.cpu.push_data = r.ps_save; // [RULE_07]
            r_nxt.state = PVI_PUSH_PS;
         end
         PVI_PUSH_PS: begin
            r_nxt.cpu.mem_rd = 1'b1;
            r_nxt.cpu.mem_addr = `PVI_VEC_TOP - {10'h000, r.cur_prio, 1'b0}; // [RULE_10] [RULE_11]
            r_nxt.state = PVI_FETCH_LO;
         end
         PVI_FETCH_LO: begin
            // High byte sits at the odd address just above the low byte
            r_nxt.cpu.mem_rd = 1'b1;
            r_nxt.cpu.mem_addr = r.cpu.mem_addr | 16'h0001; // [RULE_10]
            r_nxt.state = PVI_FETCH_HI;
         end
         PVI_FETCH_HI: begin
            r_nxt.vec_lo = mem_rdata;
            r_nxt.state = PVI_LOAD;
         end
         PVI_LOAD: begin
            r_nxt.cpu.pc_load = 1'b1;
            r_nxt.cpu.pc_new = {mem_rdata, r.vec_lo}; // [RULE_09]
            r_nxt.state = PVI_IDLE;
         end
         default: begin
            r_nxt.state = PVI_IDLE;
         end
      endcase
      // A new event beats a clear in the same cycle, so nothing is lost
      r_nxt.req = (r.req & clr) | ev; // [RULE_03] [RULE_22] [RULE_21]
      if (software_break_op) begin
         r_nxt.swb_pend = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n_i) begin
      if (!rst_n_i) begin
         r <= '{state: PVI_IDLE, rst_pend: 1'b1, mask: 1'b1, default: '0}; // [RULE_12]
      end else begin
         r <= r_nxt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n_i);

   sequence push_three;
      r.cpu.push_stb [*3];
   endsequence
   sequence fetch_pair;
      r.cpu.mem_rd [*2] ##2 r.cpu.pc_load;
   endsequence

   chk_stack_then_vector: assert property (take && !r.rst_pend |=> push_three ##1 fetch_pair) // [RULE_07]
      else $error("stacking or vector fetch out of order");
   chk_mask_on_accept: assert property (take |=> r.mask) // [RULE_08]
      else $error("mask not set on acceptance");
   chk_req_cleared: assert property (take && !r.rst_pend && cpu_irq && !ev[first_idx[3:0]]
      |=> !r.req[$past(first_idx[3:0])]) // [RULE_08]
      else $error("accepted request not cleared");
   chk_no_soft_set: assert property (((r.req & ~$past(r.req)) & ~$past(ev)) == 15'h0000) // [RULE_03]
      else $error("request set without a hardware event");
   chk_break_unmasked: assert property (r.state == PVI_IDLE && cpu_boundary && !r.cpu.pc_load && !r.rst_pend
      && r.swb_pend && r.mask |=> r.state == PVI_PUSH_PCH) // [RULE_04]
      else $error("break held off");
   chk_highest_first: assert property (take && !r.rst_pend && cpu_irq |=> r.cur_prio == $past(first_idx) + 5'h01
      && !$past(qual[0]) || r.cur_prio == 5'h01) // [RULE_06]
      else $error("lower priority taken first");
   chk_vector_pair: assert property (r.cpu.mem_rd && $past(r.cpu.mem_rd)
      |-> r.cpu.mem_addr == ($past(r.cpu.mem_addr) | 16'h0001) && !$past(r.cpu.mem_addr[0])) // [RULE_10]
      else $error("vector bytes not an even/odd pair");
   chk_vector_step: assert property ($rose(r.cpu.mem_rd)
      |-> r.cpu.mem_addr == `PVI_VEC_TOP - {10'h000, r.cur_prio, 1'b0}) // [RULE_11] [RULE_12]
      else $error("vector address off its priority slot");
   chk_pc_from_vector: assert property (r.state == PVI_LOAD |=> r.cpu.pc_load
      && r.cpu.pc_new == {$past(mem_rdata), $past(r.vec_lo)}) // [RULE_09]
      else $error("program counter not loaded from vector");
   chk_bus_reset_time: assert property ($rose(r.req[0]) |-> $past(r.se0_cnt) == BUS_RESET_CYC - 9'h001) // [RULE_13]
      else $error("bus reset request at wrong SE0 length");
   chk_key_fall: assert property ($rose(r.req[13]) |-> $past(key_and_prev) && !$past(key_and_now)) // [RULE_17]
      else $error("key request without a falling AND");
   chk_irq_gate: assert property (cpu_irq |-> !r.mask && (r.req & r.en) != 15'h0000) // [RULE_01]
      else $error("interrupt raised without qualification");
endmodule

/* common/pvi_defines.svh */
// Operation
// [RULE_01] Interrupt needs request, enable, mask clear
// [RULE_02] Software sets or clears enable bits freely
// [RULE_03] Software clears requests, never sets them
// [RULE_04] Software break is never suppressed
// [RULE_05] Mask flag holds off all but break
// [RULE_06] Simultaneous requests taken by fixed priority
// [RULE_07] Acceptance pushes program counter and status
// [RULE_08] Acceptance sets mask, clears accepted request
// [RULE_09] Program counter loaded from vector entry
// [RULE_10] Two-byte vectors, stepping down from FFFC
// [RULE_11] Seventeen fixed priorities, reset first, break last
// [RULE_12] Reset handled as highest priority interrupt
// [RULE_13] Bus reset after 2.5 us SE0
// [RULE_14] USB device: resume, 3 ms suspend, transaction
// [RULE_15] External pins A, B on selected edge
// [RULE_16] Counter pin on selected edge
// [RULE_17] Key request when input-pin AND falls
// [RULE_18] Each timer underflow sets its request
// [RULE_19] Bus, serial, hub, converter completions set requests
// [RULE_20] Software disables source around edge changes
// [RULE_21] Sixteen sources: four external, eleven internal, one software
// [RULE_22] Request stays set until cleared or accepted
`ifndef PVI_DEFINES_SVH
`define PVI_DEFINES_SVH
`define PVI_REG_REQ_LO 8'h00
`define PVI_REG_REQ_HI 8'h01
`define PVI_REG_EN_LO 8'h02
`define PVI_REG_EN_HI 8'h03
`define PVI_REG_EDGE 8'h04
`define PVI_REG_KEY_DIR 8'h05
`define PVI_REG_CTRL 8'h06
`define PVI_REG_ACTIVE 8'h07
`define PVI_EDGE_A 0
`define PVI_EDGE_B 1
`define PVI_EDGE_CNT 2
`define PVI_CTRL_MASK 0
`define PVI_CTRL_SUSP 1
`define PVI_VEC_TOP 16'hFFFC
`define PVI_PRIO_SWB 5'h10
`define PVI_CLK_MHZ 125
`define PVI_BUS_RESET_US_X10 25
`define PVI_BUS_RESET_CYC ((`PVI_BUS_RESET_US_X10 * `PVI_CLK_MHZ + 9) / 10)
`define PVI_SUSPEND_MS 3
`define PVI_SUSPEND_CYC (`PVI_SUSPEND_MS * `PVI_CLK_MHZ * 1000)
`endif

/* common/pvi_pkg.sv */
package pvi_pkg;
   typedef enum logic [2:0] {
      PVI_IDLE, PVI_PUSH_PCH, PVI_PUSH_PCL, PVI_PUSH_PS, PVI_FETCH_LO, PVI_FETCH_HI, PVI_LOAD
   } pvi_state_e;
   // Pins: [7:0] key port, 8 ext a, 9 ext b, 10 counter, 11 se0, 12 K state, 13 J idle
   typedef logic [13:0] pvi_pins_t;
   typedef logic [14:0] pvi_src_t;
   typedef struct packed {
      logic timer_x;
      logic timer_1;
      logic timer_2;
      logic sof;
      logic xact_done;
      logic exb_done;
      logic hub_change;
      logic rx_done;
      logic tx_done;
      logic adc_done;
   } pvi_events_s;
   typedef struct packed {
      logic push_stb;
      logic [7:0] push_data;
      logic mem_rd;
      logic [15:0] mem_addr;
      logic pc_load;
      logic [15:0] pc_new;
   } pvi_cpu_s;
   typedef struct packed {
      pvi_pins_t pin_s1;
      pvi_pins_t pin_s2;
      pvi_pins_t pin_d;
      pvi_src_t req;
      pvi_src_t en;
      logic [2:0] edge_sel;
      logic [7:0] key_dir;
      logic mask;
      logic swb_pend;
      logic rst_pend;
      logic suspended;
      logic [8:0] se0_cnt;
      logic [19:0] idle_cnt;
      pvi_state_e state;
      logic [4:0] cur_prio;
      logic [7:0] vec_lo;
      logic [15:0] pc_save;
      logic [7:0] ps_save;
      logic [7:0] rdata;
      pvi_cpu_s cpu;
   } pvi_state_s;
endpackage

/* test/pvi_cpu_model.sv */
module pvi_cpu_model import pvi_pkg::*; (
   // Clock
   input wire logic clk,
   // Core side of the unit
   input wire pvi_cpu_s cpu_out,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Vector bytes are address xor 5A, so every entry differs
   // Outside a read the bus toggles, so a late sample never matches
   initial mem_rdata = 8'h00;
   always @(posedge clk) begin
      if (cpu_out.mem_rd) begin
         mem_rdata <= cpu_out.mem_addr[7:0] ^ 8'h5A;
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

/* test/priority_vectored_interrupt_unit_tb.sv */
`include "pvi_defines.svh"
module priority_vectored_interrupt_unit_tb import pvi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Short suspend count keeps the idle test quick
   localparam int SUSP = 50;
   localparam int EVX[10] = '{14, 11, 10, 9, 3, 2, 1, 7, 6, 5};
   logic clk, resetn, reg_wr, reg_rd, cpu_boundary, software_break_op, cpu_irq;
   logic ext_irq_a, ext_irq_b, counter_pin, usb_se0, usb_k_state, usb_j_idle;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, key_wake_port, cpu_ps, mem_rdata, d;
   logic [15:0] cpu_pc, seed;
   logic [14:0] v, ev;
   logic [9:0] e;
   pvi_events_s events;
   pvi_cpu_s cpu_out;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int k;

   pvi_unit #(.SUSPEND_CYC(20'(SUSP))) pvi_unit_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .key_wake_port(key_wake_port), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
      .counter_pin(counter_pin), .usb_se0(usb_se0), .usb_k_state(usb_k_state), .usb_j_idle(usb_j_idle),
      .events(events), .cpu_boundary(cpu_boundary), .software_break_op(software_break_op),
      .cpu_pc(cpu_pc), .cpu_ps(cpu_ps), .mem_rdata(mem_rdata), .cpu_irq(cpu_irq), .cpu_out(cpu_out));
   pvi_cpu_model pvi_cpu_model_inst (.clk(clk), .cpu_out(cpu_out), .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic summarize();
      if (fail_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [7:0] vb(input logic [15:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dat;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] dat);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      // Read data stand only until the next edge, so take them mid-cycle
      @(negedge clk);
      dat = reg_rdata;
   endtask

   task automatic rd15(output logic [14:0] r);
      logic [7:0] lo, hi;
      rd(`PVI_REG_REQ_LO, lo);
      rd(`PVI_REG_REQ_HI, hi);
      r = {hi[6:0], lo};
   endtask

   task automatic clr();
      wr(`PVI_REG_REQ_LO, 8'h00);
      wr(`PVI_REG_REQ_HI, 8'h00);
   endtask

   task automatic en15(input logic [14:0] m);
      wr(`PVI_REG_EN_LO, m[7:0]);
      wr(`PVI_REG_EN_HI, {1'b0, m[14:8]});
   endtask

   // Pin paths pass two sync flops and an edge flop, so allow a few cycles
   task automatic pchk(input int b, input bit hit);
      logic [14:0] r;
      repeat (6) @(posedge clk);
      rd15(r);
      chk(16'(r), hit ? 16'(1 << b) : 16'h0000);
      clr();
   endtask

   task automatic accept(input logic [15:0] a, input bit stk);
      logic [7:0] q[$];
      logic [15:0] m[$];
      logic [15:0] pc;
      logic [7:0] ps;
      pc = seed;
      ps = lfsr(seed);
      seed = lfsr(lfsr(seed));
      @(posedge clk);
      cpu_pc <= pc;
      cpu_ps <= ps;
      cpu_boundary <= 1'b1;
      repeat (30) begin
         @(posedge clk);
         if (cpu_out.push_stb) q.push_back(cpu_out.push_data);
         if (cpu_out.mem_rd) m.push_back(cpu_out.mem_addr);
         if (cpu_out.pc_load) break;
      end
      cpu_boundary <= 1'b0;
      chk(16'(cpu_out.pc_load), 16'h0001);
      chk(cpu_out.pc_new, {vb(a | 16'h0001), vb(a)});
      chk(16'(m.size()), 16'h0002);
      chk(m[0], a);
      chk(m[1], a | 16'h0001);
      chk(16'(q.size()), stk ? 16'h0003 : 16'h0000);
      if (stk) begin
         chk({q[0], q[1]}, pc);
         chk(16'(q[2]), 16'(ps));
      end
   endtask

   initial begin
      seed = 16'h825A;
      {resetn, reg_wr, reg_rd, cpu_boundary, software_break_op, ext_irq_a, usb_se0} = '0;
      {usb_k_state, usb_j_idle, reg_addr, reg_wdata, cpu_pc, cpu_ps} = '0;
      {ext_irq_b, counter_pin, key_wake_port} = '1;
      events = '0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      accept(16'hFFFC, 1'b0);
      rd(`PVI_REG_CTRL, d);
      chk(16'(d), 16'h0001);
      rd(8'h20, d);
      chk(16'(d), 16'h0000);
      rd(`PVI_REG_EN_LO, d);
      chk(16'(d), 16'h0000);
      clr();
      wr(`PVI_REG_REQ_LO, 8'hFF);
      wr(`PVI_REG_REQ_HI, 8'h7F);
      rd15(v);
      chk(16'(v), 16'h0000);
      en15(15'h7FFF);
      rd(`PVI_REG_EN_HI, d);
      chk(16'(d), 16'h007F);
      wr(`PVI_REG_CTRL, 8'h00);
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         events <= pvi_events_s'(10'(1 << i));
         @(posedge clk);
         events <= '0;
         repeat (5) @(posedge clk);
         chk(16'(cpu_irq), 16'h0001);
         rd15(v);
         chk(16'(v), 16'(1 << EVX[i]));
         if (i == 9) begin
            en15(15'h0000);
            @(posedge clk);
            chk(16'(cpu_irq), 16'h0000);
            en15(15'h7FFF);
            wr(`PVI_REG_CTRL, 8'h01);
            @(posedge clk);
            chk(16'(cpu_irq), 16'h0000);
         end
         clr();
      end
      for (int r = 0; r < 6; r++) begin
         e = (r == 0) ? 10'h3FF : (seed[9:0] | 10'h200 >> r);
         seed = lfsr(seed);
         ev = '0;
         for (int i = 0; i < 10; i++) if (e[i]) ev[EVX[i]] = 1'b1;
         for (int j = 14; j >= 0; j--) if (ev[j]) k = j;
         clr();
         wr(`PVI_REG_CTRL, 8'h00);
         events <= pvi_events_s'(e);
         @(posedge clk);
         events <= '0;
         repeat (2) @(posedge clk);
         chk(16'(cpu_irq), 16'h0001);
         accept(16'hFFFA - 16'(2 * k), 1'b1);
         rd(`PVI_REG_CTRL, d);
         chk(16'(d[0]), 16'h0001);
         rd(`PVI_REG_ACTIVE, d);
         chk(16'(d), 16'(k + 1));
         rd15(v);
         chk(16'(v), 16'(ev & ~(15'h0001 << k)));
      end
      // Break must win even with mask set and nothing enabled
      clr();
      en15(15'h0000);
      software_break_op <= 1'b1;
      @(posedge clk);
      software_break_op <= 1'b0;
      accept(16'hFFDC, 1'b1);
      wr(`PVI_REG_EDGE, 8'h06);
      repeat (4) @(posedge clk);
      clr();
      en15(15'h7FFF);
      ext_irq_a <= 1'b1;
      pchk(4, 1'b1);
      ext_irq_a <= 1'b0;
      pchk(4, 1'b0);
      ext_irq_b <= 1'b0;
      pchk(8, 1'b1);
      counter_pin <= 1'b0;
      pchk(12, 1'b1);
      key_wake_port <= 8'hF7;
      pchk(13, 1'b1);
      key_wake_port <= 8'hFF;
      pchk(13, 1'b0);
      wr(`PVI_REG_KEY_DIR, 8'h01);
      key_wake_port <= 8'hFE;
      pchk(13, 1'b0);
      usb_se0 <= 1'b1;
      repeat (300) @(posedge clk);
      usb_se0 <= 1'b0;
      pchk(0, 1'b0);
      usb_se0 <= 1'b1;
      repeat (330) @(posedge clk);
      usb_se0 <= 1'b0;
      pchk(0, 1'b1);
      usb_j_idle <= 1'b1;
      repeat (SUSP + 20) @(posedge clk);
      pchk(2, 1'b1);
      rd(`PVI_REG_CTRL, d);
      chk(16'(d[1]), 16'h0001);
      usb_j_idle <= 1'b0;
      usb_k_state <= 1'b1;
      repeat (3) @(posedge clk);
      usb_k_state <= 1'b0;
      pchk(2, 1'b1);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      accept(16'hFFFC, 1'b0);
      summarize();
   end
endmodule
